// ### design/wrw_pkg.sv
// Constants, types and shared layout for the windowed reset watchdog.
// Assumes a single 100 MHz machine clock and a synchronous active-high reset.
//
// Contract
// - Count decrements once per 16000 machine cycles via an internal prescaler.
// - Timeout is programmable in 64 steps of one decrement period.
// - Active watchdog resets chip when count steps 40h to 3Fh.
// - Expiry reset drives the external reset line low for about 30 us.
// - Counter keeps decrementing even when the watchdog is inactive.
// - Watchdog inactive after reset; only reset deactivates it; here an option write clearing hw_watchdog does so while act_q is 0.
// - Setting activation with top count bit clear resets immediately.
// - HALT while active resets the chip unless the halt option is set.
// - Hardware watchdog option forces activation; software bit ignored.
// - With the halt option, HALT enters halt mode without reset.
// - Refresh does not clear the prescaler, so expiry time varies.
// - Reset phase of 256 or 4096 CPU cycles follows expiry; the long setting reports 4095 (FFFh) here.
// - Control register: activation bit 7, count bits 6..0, resets to 7Fh.
// - Activation bit set by software, cleared only by reset.
package wrw_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned PRESCALE_CYCLES = 16000;
   localparam int unsigned RESET_PULSE_NS = 30000;
   localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned RESET_PHASE_SHORT = 256;
   localparam int unsigned RESET_PHASE_LONG = 4096;

   // ------------------------------------------------------------------
   // Register map and fields
   // ------------------------------------------------------------------
   localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
   localparam logic [31:0] OPT_OFFSET = 32'h0000_0004;
   localparam logic [31:0] STAT_OFFSET = 32'h0000_0008;
   localparam int unsigned ACT_BIT = 7;
   localparam int unsigned TOP_BIT = 6;
   localparam logic [6:0] COUNT_RESET = 7'h7f;
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // Reset cause encoding.
   typedef enum logic [1:0] {
      WRW_CAUSE_NONE = 2'b00,
      WRW_CAUSE_EXPIRE = 2'b01,
      WRW_CAUSE_SOFT = 2'b10,
      WRW_CAUSE_HALT = 2'b11
   } wrw_cause_t;

   // Control register image.
   typedef struct packed {
      logic activation_flag;
      logic [6:0] count;
   } wrw_ctrl_t;

   // Option byte settings.
   typedef struct packed {
      logic hw_watchdog;
      logic halt_without_reset_option;
      logic long_reset_phase;
   } wrw_opt_t;

endpackage : wrw_pkg

// ### design/wrw_prescaler.sv
// Free-running prescaler producing one-cycle tick pulses.
// Assumes the machine clock and synchronous reset of the watchdog.
`timescale 1ns/1ns
module wrw_prescaler #(
   parameter int unsigned DIVIDE = 16000
) (
   input wire logic mclk,
   input wire logic sys_rst,
   output logic tick
);
   localparam int unsigned W = $clog2(DIVIDE);
   localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

   logic [W-1:0] cnt_q;

   // ------------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------------
   // Never cleared by software so a refresh leaves the phase alone.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_q <= '0;
      end else if (cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   // Tick on the final cycle of each period.
   assign tick = (cnt_q == LAST);
endmodule : wrw_prescaler

// ### design/wrw_reset_pulse.sv
// Reset pulse stretcher: holds the external reset line low for a fixed count.
// Assumes start is a one-cycle pulse in the machine clock domain.
`timescale 1ns/1ns
module wrw_reset_pulse #(
   parameter int unsigned LENGTH = 3000
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic start,
   output logic reset_out_n
);
   localparam int unsigned W = $clog2(LENGTH + 1);

   logic [W-1:0] left_q;

   // ------------------------------------------------------------------
   // Stretch counter
   // ------------------------------------------------------------------
   // A new start restarts the full length; the chip reset is not shortened.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         left_q <= '0;
      end else if (start) begin
         left_q <= W'(LENGTH);
      end else if (left_q != '0) begin
         left_q <= left_q - W'(1);
      end
   end

   // Registered so the pin is glitch-free.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reset_out_n <= 1'b1;
      end else begin
         reset_out_n <= ~(start || left_q > W'(1));
      end
   end
endmodule : wrw_reset_pulse

// ### design/wrw_watchdog.sv
// Windowed reset watchdog top: AXI4-Lite slave, down-counter and reset request.
// Assumes the system feeds reset_out_n back into sys_rst and halt_req from the CPU.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
module wrw_watchdog #(
   parameter int unsigned PRESCALE = wrw_pkg::PRESCALE_CYCLES,
   parameter int unsigned PULSE = wrw_pkg::RESET_PULSE_CYCLES
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic halt_req,
   output logic halt_grant,
   output logic reset_out_n,
   output logic [11:0] reset_phase_cycles
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic act_q;
   logic [6:0] count_q;
   wrw_pkg::wrw_opt_t opt_q;
   wrw_pkg::wrw_cause_t cause_q;
   logic [31:0] awaddr_q;
   logic aw_held_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic w_held_q;
   logic tick;
   logic active;
   logic wr_fire;
   logic ctrl_wr;
   logic opt_wr;
   logic expire;
   logic soft_rst;
   logic halt_rst;
   logic rst_req;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;

   // Word-aligned decode used by both the read and the write paths.
   function automatic logic [1:0] decode(input logic [31:0] addr);
      logic [1:0] sel;
      sel = 2'h3;
      if (addr[31:2] == wrw_pkg::CTRL_OFFSET[31:2]) begin
         sel = 2'h0;
      end else if (addr[31:2] == wrw_pkg::OPT_OFFSET[31:2]) begin
         sel = 2'h1;
      end else if (addr[31:2] == wrw_pkg::STAT_OFFSET[31:2]) begin
         sel = 2'h2;
      end
      return sel;
   endfunction : decode

   // ------------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------------
   wrw_prescaler #(
      .DIVIDE(PRESCALE)
   ) u_pre (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .tick(tick)
   );

   wrw_reset_pulse #(
      .LENGTH(PULSE)
   ) u_pulse (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .start(rst_req),
      .reset_out_n(reset_out_n)
   );

   // ------------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------------
   // Address and data are captured independently in either order.
   assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
   assign wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
   assign wr_data = w_held_q ? wdata_q : s_axi_wdata;
   assign wr_fire = (aw_held_q | (s_axi_awvalid & s_axi_awready))
      & (w_held_q | (s_axi_wvalid & s_axi_wready));

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 32'h0000_0000;
      end else if (wr_fire) begin
         aw_held_q <= 1'b0;
      end else if (s_axi_awvalid & s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (wr_fire) begin
         w_held_q <= 1'b0;
      end else if (s_axi_wvalid & s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
   end

   // Write response; unmapped or read-only targets answer SLVERR.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= wrw_pkg::AXI_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (decode(wr_addr) < 2'h2) ? wrw_pkg::AXI_OKAY : wrw_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Only the low byte lane carries register bits.
   assign ctrl_wr = wr_fire & (decode(wr_addr) == 2'h0)
      & (w_held_q ? wstrb_q[0] : s_axi_wstrb[0]);
   assign opt_wr = wr_fire & (decode(wr_addr) == 2'h1)
      & (w_held_q ? wstrb_q[0] : s_axi_wstrb[0]);

   // ------------------------------------------------------------------
   // Watchdog core
   // ------------------------------------------------------------------
   // Option settings stand in for the option byte and survive only until reset.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         opt_q <= '0;
      end else if (opt_wr) begin
         opt_q <= wr_data[2:0];
      end
   end

   // Activation is sticky: a zero write never clears it.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         act_q <= 1'b0;
      end else if (ctrl_wr & wr_data[wrw_pkg::ACT_BIT]) begin
         act_q <= 1'b1;
      end
   end

   assign active = act_q | opt_q.hw_watchdog;

   // Free-running counter; a write replaces the count, else a tick decrements it.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_q <= wrw_pkg::COUNT_RESET;
      end else if (ctrl_wr) begin
         count_q <= wr_data[6:0];
      end else if (tick) begin
         count_q <= count_q - 7'h01;
      end
   end

   // Expiry is the 40h to 3Fh step; each low-bit step is one period.
   assign expire = active & tick & ~ctrl_wr & (count_q == 7'h40);
   assign soft_rst = ctrl_wr & ~wr_data[wrw_pkg::TOP_BIT]
      & (wr_data[wrw_pkg::ACT_BIT] | active);
   assign halt_rst = halt_req & active & ~opt_q.halt_without_reset_option;
   assign halt_grant = halt_req & ~halt_rst;
   assign rst_req = expire | soft_rst | halt_rst;

   // Cause of the most recent request; visible until the system reset lands.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cause_q <= wrw_pkg::WRW_CAUSE_NONE;
      end else if (expire) begin
         cause_q <= wrw_pkg::WRW_CAUSE_EXPIRE;
      end else if (soft_rst) begin
         cause_q <= wrw_pkg::WRW_CAUSE_SOFT;
      end else if (halt_rst) begin
         cause_q <= wrw_pkg::WRW_CAUSE_HALT;
      end
   end

   // Reset phase length reported to the reset controller.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         reset_phase_cycles <= 12'(wrw_pkg::RESET_PHASE_SHORT);
      end else begin
         reset_phase_cycles <= opt_q.long_reset_phase
            ? 12'(wrw_pkg::RESET_PHASE_LONG - 1) : 12'(wrw_pkg::RESET_PHASE_SHORT);
      end
   end

   // ------------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------------
   // One read at a time; rvalid blocks further addresses.
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= wrw_pkg::AXI_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= wrw_pkg::AXI_OKAY;
         unique case (decode(s_axi_araddr))
            2'h0: begin
               s_axi_rdata <= {24'h000000, active, count_q};
            end
            2'h1: begin
               s_axi_rdata <= {29'h00000000, opt_q};
            end
            2'h2: begin
               s_axi_rdata <= {30'h00000000, cause_q};
            end
            2'h3: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= wrw_pkg::AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : wrw_watchdog

// ### test/wrw_watchdog_monitor.sv
// Checker for the watchdog top: bus answers, halt handling and reset pulse.
// Assumes it is bound to the top module and PULSE matches the instance.
`timescale 1ns/1ns
module wrw_watchdog_monitor #(
   parameter int unsigned PULSE = 5
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] s_axi_rresp,
   input wire logic halt_req,
   input wire logic halt_grant,
   input wire logic reset_out_n,
   input wire logic [11:0] reset_phase_cycles
);
   logic [15:0] low_q;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   // Counts consecutive low samples, so the pulse length is checked exactly.
   always_ff @(posedge mclk) begin
      if (sys_rst || reset_out_n) begin
         low_q <= 16'h0;
      end else begin
         low_q <= low_q + 16'h1;
      end
   end

   a_pulse_exact_len: assert property ($rose(reset_out_n) |-> low_q == PULSE)
      else $error("reset pulse length differs");
   a_pulse_no_overrun: assert property (!reset_out_n |-> low_q < PULSE)
      else $error("reset pulse too long");
   a_halt_gives_reset: assert property (halt_req && !halt_grant && reset_out_n |=> !reset_out_n)
      else $error("refused halt made no reset");
   a_grant_needs_halt: assert property (halt_grant |-> halt_req)
      else $error("halt granted without request");
   a_phase_legal: assert property (reset_phase_cycles == 12'h100 || reset_phase_cycles == 12'hfff)
      else $error("reset phase value illegal");
   a_write_answered: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid)
      else $error("write not answered");
   a_read_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");

   c_reset_pulse: cover property ($fell(reset_out_n));
   c_halt_granted: cover property (halt_grant);
   c_read_error: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : wrw_watchdog_monitor

bind wrw_watchdog wrw_watchdog_monitor #(.PULSE(PULSE)) i_wrw_watchdog_monitor (.mclk, .sys_rst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .halt_req, .halt_grant, .reset_out_n,
   .reset_phase_cycles);

// ### test/wrw_watchdog_tb.sv
// Self-checking bench for the watchdog: bus tasks and scripted tests.
// Assumes shortened PRESCALE and PULSE so every count is reached quickly.
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t got %h exp %h", $time, g, e); end end
module wrw_watchdog_tb;
   localparam int unsigned PS = 16;
   localparam int unsigned PL = 5;
   logic mclk = 1'h0;
   logic sys_rst = 1'h1;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_rready = 1'h0, halt_req = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, halt_grant;
   logic reset_out_n;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [11:0] reset_phase_cycles;
   int errors = 0, tests_run = 0, cyc = 0, lows = 0, w, l0;

   wrw_watchdog #(.PRESCALE(PS), .PULSE(PL)) i_wrw_watchdog (.mclk, .sys_rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halt_req, .halt_grant,
      .reset_out_n, .reset_phase_cycles);

   initial forever #5 mclk = ~mclk;

   // Counts low cycles of the reset line; sampled mid-cycle to stay clear of the edge.
   always @(negedge mclk) if (reset_out_n === 1'h0) lows++;

   // A hang is counted as a mismatch and cut short.
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         conclude();
      end
   end

   // Handshake state is sampled at the falling edge, released after the taking edge.
   task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      tb = 1'h0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (!tb) begin
         @(negedge mclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge mclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
         if (tb) s_axi_bready <= 1'h0;
      end
      `CHK(r, er)
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] v);
      logic ta, tr;
      logic [1:0] r;
      tr = 1'h0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (!tr) begin
         @(negedge mclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         v = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge mclk);
         if (ta) s_axi_arvalid <= 1'h0;
         if (tr) s_axi_rready <= 1'h0;
      end
      `CHK(r, er)
   endtask : rd

   task automatic rst();
      @(posedge mclk);
      sys_rst <= 1'h1;
      halt_req <= 1'h0;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'h0;
   endtask : rst

   // Waits for the reset line to fall, then for the whole pulse to pass.
   task automatic pulse(input int lim);
      w = 0;
      l0 = lows;
      while (reset_out_n !== 1'h0 && w < lim) begin
         @(negedge mclk);
         w++;
      end
      repeat (PL + 2) @(negedge mclk);
   endtask : pulse

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   initial begin
      rst();
      `CHK(reset_phase_cycles, 12'h100)
      rd(32'h0, 2'h0, d);
      `CHK(d[7:0], 8'h7f)
      // Inactive: the count passes 40h and keeps falling with no reset.
      wr(32'h0, 32'h41, 2'h0);
      repeat (48) @(posedge mclk);
      rd(32'h0, 2'h0, d);
      `CHK(d[7:0] inside {8'h3e, 8'h3d}, 1'h1)
      `CHK(lows, 0)
      wr(32'h0, 32'hff, 2'h0);
      wr(32'h0, 32'h7f, 2'h0);
      rd(32'h0, 2'h0, d);
      `CHK(d[7], 1'h1)
      `CHK(d[6:0] inside {7'h7f, 7'h7e}, 1'h1)
      $display("test done: count and activation");
      // Active: two steps from 41h must expire and pulse the line.
      wr(32'h0, 32'hc1, 2'h0);
      pulse(80);
      `CHK(w inside {[12:34]}, 1'h1)
      `CHK(lows - l0, PL)
      rd(32'h8, 2'h0, d);
      `CHK(d[1:0], 2'h1)
      rst();
      rd(32'h0, 2'h0, d);
      `CHK(d[7], 1'h0)
      wr(32'h0, 32'h80, 2'h0);
      pulse(4);
      `CHK(w < 4, 1'h1)
      rd(32'h8, 2'h0, d);
      `CHK(d[1:0], 2'h2)
      $display("test done: expiry and soft reset");
      // Halt refused while active, granted with the halt option.
      rst();
      wr(32'h0, 32'hff, 2'h0);
      halt_req <= 1'h1;
      @(negedge mclk);
      `CHK(halt_grant, 1'h0)
      // A refused halt stands for one edge only, as the chip reset would end it.
      @(posedge mclk);
      halt_req <= 1'h0;
      pulse(3);
      `CHK(w < 3, 1'h1)
      rd(32'h8, 2'h0, d);
      `CHK(d[1:0], 2'h3)
      rst();
      wr(32'h4, 32'h2, 2'h0);
      wr(32'h0, 32'hff, 2'h0);
      l0 = lows;
      halt_req <= 1'h1;
      repeat (4) @(negedge mclk);
      `CHK(halt_grant, 1'h1)
      `CHK(lows, l0)
      $display("test done: halt");
      // Hardware option, long phase and refused addresses.
      rst();
      wr(32'h4, 32'h5, 2'h0);
      rd(32'h0, 2'h0, d);
      `CHK(d[7], 1'h1)
      `CHK(reset_phase_cycles, 12'hfff)
      rd(32'h10, 2'h2, d);
      `CHK(d, 32'h0)
      wr(32'h8, 32'h0, 2'h2);
      $display("test done: options and map");
      conclude();
   end
endmodule : wrw_watchdog_tb
